// *** scs_pkg.sv ***
// constants and types shared by the strap latch and serial configuration block
package scs_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned ClkFreqHz     = 100_000_000;
  localparam int unsigned SelectTimeUs  = 2000;
  localparam int unsigned SelectCycles  = SelectTimeUs * (ClkFreqHz / 1_000_000);

  // ==========================================================================
  // serial byte framing
  localparam logic [3:0] BitLastData    = 4'h7;
  localparam logic [3:0] BitAck         = 4'h8;
  localparam logic [7:0] AddrByte       = 8'hd2;
  localparam logic [3:0] PosAddr        = 4'h0;
  localparam logic [3:0] PosCfgFirst    = 4'h6;
  localparam logic [3:0] PosCfgLast     = 4'h9;
  localparam logic [3:0] PosDone        = 4'ha;

  // ==========================================================================
  // configuration bytes after power-up
  localparam logic [7:0] Byte3Reset     = 8'h02;
  localparam logic [7:0] Byte4Reset     = 8'h45;
  localparam logic [7:0] Byte5Reset     = 8'hef;
  localparam logic [7:0] Byte6Reset     = 8'h00;

  // ==========================================================================
  // field positions
  localparam int unsigned B3SelHi       = 7;
  localparam int unsigned B3SelLo       = 4;
  localparam int unsigned B3TableSel    = 3;
  localparam int unsigned B4Usb         = 6;
  localparam int unsigned B4Proc1       = 2;
  localparam int unsigned B4Proc0       = 0;
  localparam int unsigned B5PciF        = 7;
  localparam int unsigned B5Pci6        = 6;
  localparam int unsigned B5Pci5        = 5;
  localparam int unsigned B5Pci4        = 3;
  localparam int unsigned B5Pci3        = 2;
  localparam int unsigned B5Pci2        = 1;
  localparam int unsigned B5Pci1        = 0;

  // output mode field, byte 3 bits 1..0
  localparam logic [1:0] ModeSpreadOff  = 2'h0;
  localparam logic [1:0] ModeTest       = 2'h1;
  localparam logic [1:0] ModeSpreadOn   = 2'h2;
  localparam logic [1:0] ModeTriState   = 2'h3;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [7:0] byte6;
    logic [7:0] byte5;
    logic [7:0] byte4;
    logic [7:0] byte3;
  } scs_cfg_type;

  typedef struct packed {
    logic ref14;
    logic usb48;
    logic usb24;
    logic proc;
    logic pci;
  } scs_src_type;

  typedef struct packed {
    logic       useRegs;
    logic [3:0] sel;
    logic [1:0] fsPins;
    logic       spreadOn;
  } scs_freq_type;

  typedef enum logic [1:0] {
    StWaitSupply,
    StSelect,
    StLatch,
    StRun
  } scs_state_type;

endpackage

// *** scs_strap_cfg.sv ***
// strap latching, serial configuration port and clock output control
`timescale 1ns/1ps

// ============================================================================
// two-flop level synchroniser
module scs_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ============================================================================
// Functional notes
// (R1) after power-up both dual pins act as inputs during the selection period
// (R2) dual pin drivers stay high impedance for the whole selection period
// (R3) at period end capture each pin level, then enable its driver
// (R4) strap to ground latches zero, strap to supply latches one
// (R5) selection timer starts only once supply reaches its start threshold
// (R6) strap latches hold until power is removed and reapplied
// (R7) doubled reference pin outputs the reference clock once enabled
// (R8) processor outputs may emit one short cycle when first enabled
// (R9) serial port is write only, never returns read data
// (R10) configuration registers take defaults at power-up
// (R11) a write is ten bytes: address, command, count, data bytes zero to six
// (R12) wrong address byte leaves all configuration registers unchanged
// (R13) command and count bytes are counted for position, values ignored
// (R14) data bytes zero to two are ignored
// (R15) data bytes three to six update registers only after matching address
// (R16) each clock output can be disabled; disabled outputs drive low; the doubled reference pin has no enable bit here
// (R17) registers extend frequency choices; change ramps smoothly
// (R18) three-state setting floats every clock output at once
// (R19) test mode bypasses the pll, outputs follow the crystal input
// (R20) host writes zero to every reserved bit
// (R21) bits arrive most significant first
// (R22) rate strap zero gives 48 MHz on the usb pin, one gives 24 MHz
// (R23) selection period is a cycle counter ending in latch then enable
module scs_strap_cfg #(
  parameter int unsigned SelectCount = scs_pkg::SelectCycles
) (
  // system clock, reset and enable
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 clockEn,
  // supply monitor
  input  wire logic                 supplyOk,
  // clock sources from the synthesizer core and crystal
  input  wire logic                 crystal_in,
  input  wire scs_pkg::scs_src_type clkSrc,
  // frequency straps
  input  wire logic                 freq_select_strap0,
  // serial configuration link
  input  wire logic                 cfg_serial_clock,
  input  wire logic                 cfgSerialDataIn,
  output logic                      cfgSerialDataOut,
  output logic                      cfgSerialDataOe_n,
  // doubled reference pin, strap input before enable
  input  wire logic                 doubledRefIn,
  output logic                      doubled_ref_out,
  output logic                      doubledRefOe_n,
  // usb rate pin, second frequency strap before enable
  input  wire logic                 usbRateIn,
  output logic                      usb_rate_out,
  output logic                      usbRateOe_n,
  // processor and bus clock outputs
  output logic [1:0]                proc_clk_out,
  output logic                      procClkOe_n,
  output logic [6:0]                pciClkOut,
  output logic                      pciClkOe_n,
  // status and synthesizer control
  output logic                      outputsRunning,
  output logic                      rate48_strap,
  output logic [1:0]                freq_select_straps,
  output scs_pkg::scs_freq_type     freqCtrl,
  output logic                      pllBypass,
  output logic [7:0]                cfgByte6
);

  // ==========================================================================
  // link domain: bit assembly on the serial clock
  logic       frameClr_q;
  logic       linkRst_n;
  logic [3:0] bitCnt_q;
  logic [6:0] shift_q;
  logic [7:0] linkByte_q;
  logic       linkTgl_q;

  // the main domain holds this clear while the clock is high after a start,
  // so the counter is released only while the serial clock is low
  assign linkRst_n = rst_n & ~frameClr_q;

  always_ff @(posedge cfg_serial_clock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      bitCnt_q <= 4'h0;
      shift_q  <= 7'h00;
    end else if (bitCnt_q == scs_pkg::BitAck) begin
      bitCnt_q <= 4'h0;
    end else begin
      bitCnt_q <= bitCnt_q + 4'h1;
      shift_q  <= {shift_q[5:0], cfgSerialDataIn}; // [R21]
    end
  end

  // byte and toggle are never cleared by the frame, so the handshake stays in step
  always_ff @(posedge cfg_serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      linkByte_q <= 8'h00;
      linkTgl_q  <= 1'b0;
    end else if (bitCnt_q == scs_pkg::BitLastData) begin
      linkByte_q <= {shift_q, cfgSerialDataIn}; // [R21]
      linkTgl_q  <= ~linkTgl_q;
    end
  end

  // ==========================================================================
  // crossings into the system clock
  logic sclS;
  logic sdaS;
  logic tglS;
  logic supS;
  logic refPinS;
  logic usbPinS;
  logic fs0S;

  scs_sync uSyncScl (.clock(clock), .rst_n(rst_n), .din(cfg_serial_clock), .dout(sclS));
  scs_sync uSyncSda (.clock(clock), .rst_n(rst_n), .din(cfgSerialDataIn), .dout(sdaS));
  scs_sync uSyncTgl (.clock(clock), .rst_n(rst_n), .din(linkTgl_q), .dout(tglS));
  scs_sync uSyncSup (.clock(clock), .rst_n(rst_n), .din(supplyOk), .dout(supS));
  scs_sync uSyncRef (.clock(clock), .rst_n(rst_n), .din(doubledRefIn), .dout(refPinS));
  scs_sync uSyncUsb (.clock(clock), .rst_n(rst_n), .din(usbRateIn), .dout(usbPinS));
  scs_sync uSyncFs0 (.clock(clock), .rst_n(rst_n), .din(freq_select_strap0), .dout(fs0S));

  // ==========================================================================
  // frame events
  logic sclPrev_q;
  logic sdaPrev_q;
  logic tglPrev_q;
  logic startEv;
  logic stopEv;
  logic sclFall;
  logic byteEv;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_q <= 1'b0;
      sdaPrev_q <= 1'b1;
      tglPrev_q <= 1'b0;
    end else if (clockEn) begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
      tglPrev_q <= tglS;
    end
  end

  assign startEv = clockEn & sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopEv  = clockEn & sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  assign sclFall = clockEn & sclPrev_q & ~sclS;
  assign byteEv  = clockEn & (tglS ^ tglPrev_q);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frameClr_q <= 1'b0;
    end else if (startEv) begin
      frameClr_q <= 1'b1;
    end else if (clockEn & ~sclS) begin
      frameClr_q <= 1'b0;
    end
  end

  // ==========================================================================
  // byte sequencing and address match
  logic [3:0] byteIdx_q;
  logic       matched_q;
  logic       addrHit;
  logic       cfgSlot;

  assign addrHit = byteEv & (byteIdx_q == scs_pkg::PosAddr) & (linkByte_q == scs_pkg::AddrByte); // [R12]
  // positions one to five (command, count, data 0..2) only advance the index
  assign cfgSlot = byteEv & matched_q & (byteIdx_q >= scs_pkg::PosCfgFirst)
                   & (byteIdx_q <= scs_pkg::PosCfgLast); // [R13] [R14] [R15]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      byteIdx_q <= 4'h0;
      matched_q <= 1'b0;
    end else if (startEv | stopEv) begin
      byteIdx_q <= 4'h0;
      matched_q <= 1'b0;
    end else if (byteEv) begin
      if (byteIdx_q != scs_pkg::PosDone) begin
        byteIdx_q <= byteIdx_q + 4'h1; // [R11] [R13]
      end
      if (addrHit) begin
        matched_q <= 1'b1; // [R12]
      end
    end
  end

  // ==========================================================================
  // configuration registers
  scs_pkg::scs_cfg_type cfg_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q.byte3 <= scs_pkg::Byte3Reset; // [R10]
      cfg_q.byte4 <= scs_pkg::Byte4Reset; // [R10]
      cfg_q.byte5 <= scs_pkg::Byte5Reset; // [R10]
      cfg_q.byte6 <= scs_pkg::Byte6Reset; // [R10]
    end else if (cfgSlot) begin
      case (byteIdx_q)
        4'h6: cfg_q.byte3 <= linkByte_q; // [R15]
        4'h7: cfg_q.byte4 <= linkByte_q; // [R15]
        4'h8: cfg_q.byte5 <= linkByte_q; // [R15]
        4'h9: cfg_q.byte6 <= linkByte_q; // [R15]
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // ==========================================================================
  // acknowledge: the only time the data pin is pulled low
  logic ackPend_q;
  logic ackDrive_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ackPend_q  <= 1'b0;
      ackDrive_q <= 1'b0;
    end else if (startEv | stopEv) begin
      ackPend_q  <= 1'b0;
      ackDrive_q <= 1'b0;
    end else if (clockEn) begin
      if (byteEv & (addrHit | (matched_q & byteIdx_q != scs_pkg::PosDone))) begin
        ackPend_q <= 1'b1;
      end else if (sclFall & ackPend_q) begin
        ackPend_q <= 1'b0;
      end
      if (sclFall) begin
        ackDrive_q <= ackPend_q & ~ackDrive_q;
      end
    end
  end

  // no read path exists: a read address never matches, nothing is shifted out
  assign cfgSerialDataOut  = 1'b0; // [R9]
  assign cfgSerialDataOe_n = ~ackDrive_q; // [R9]

  // ==========================================================================
  // power-up selection period and strap latches
  scs_pkg::scs_state_type state_q;
  logic [17:0]            selCnt_q;
  logic                   rate48_q;
  logic                   fs1_q;
  logic                   fs0_q;
  logic                   selDone;

  assign selDone = (selCnt_q == 18'(SelectCount - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= scs_pkg::StWaitSupply;
      selCnt_q <= 18'h00000;
    end else if (clockEn) begin
      case (state_q)
        scs_pkg::StWaitSupply: begin
          if (supS) begin
            state_q <= scs_pkg::StSelect; // [R5]
          end
        end
        scs_pkg::StSelect: begin
          selCnt_q <= selCnt_q + 18'h00001; // [R23]
          if (selDone) begin
            state_q <= scs_pkg::StLatch; // [R23]
          end
        end
        scs_pkg::StLatch: state_q <= scs_pkg::StRun; // [R3] [R23]
        scs_pkg::StRun:   state_q <= scs_pkg::StRun; // [R6]
        default:          state_q <= scs_pkg::StWaitSupply;
      endcase
    end
  end

  // latches are written only once; only a fresh power-up reset clears them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate48_q <= 1'b0;
      fs1_q    <= 1'b0;
      fs0_q    <= 1'b0;
    end else if (clockEn & (state_q == scs_pkg::StLatch)) begin
      rate48_q <= refPinS; // [R3] [R4] [R6]
      fs1_q    <= usbPinS; // [R3] [R4] [R6]
      fs0_q    <= fs0S;
    end
  end

  // ==========================================================================
  // clock output control
  logic       running;
  logic       testMode;
  logic       triState;
  logic [1:0] procEn;
  logic [6:0] pciEn;
  logic       procSrc;
  logic       pciSrc;
  logic       usbSrc;

  assign running  = (state_q == scs_pkg::StRun);
  assign testMode = (cfg_q.byte3[1:0] == scs_pkg::ModeTest);
  assign triState = (cfg_q.byte3[1:0] == scs_pkg::ModeTriState);
  assign procEn   = {cfg_q.byte4[scs_pkg::B4Proc1], cfg_q.byte4[scs_pkg::B4Proc0]};
  assign pciEn    = {cfg_q.byte5[scs_pkg::B5Pci6], cfg_q.byte5[scs_pkg::B5Pci5],
                     cfg_q.byte5[scs_pkg::B5Pci4], cfg_q.byte5[scs_pkg::B5Pci3],
                     cfg_q.byte5[scs_pkg::B5Pci2], cfg_q.byte5[scs_pkg::B5Pci1],
                     cfg_q.byte5[scs_pkg::B5PciF]};

  // test mode swaps every source for the crystal
  assign procSrc = testMode ? crystal_in : clkSrc.proc; // [R19]
  assign pciSrc  = testMode ? crystal_in : clkSrc.pci; // [R19]
  assign usbSrc  = testMode ? crystal_in : (rate48_q ? clkSrc.usb24 : clkSrc.usb48); // [R19] [R22]

  // combinational gating: enabling mid-cycle can clip the first processor cycle
  assign proc_clk_out    = {2{running & procSrc}} & procEn; // [R8] [R16]
  assign pciClkOut       = {7{running & pciSrc}} & pciEn; // [R16]
  assign doubled_ref_out = running & (testMode ? crystal_in : clkSrc.ref14); // [R7] [R19]
  assign usb_rate_out    = running & usbSrc & cfg_q.byte4[scs_pkg::B4Usb]; // [R16] [R22]

  assign doubledRefOe_n = ~running | triState; // [R1] [R2] [R18]
  assign usbRateOe_n    = ~running | triState; // [R1] [R2] [R18]
  assign procClkOe_n    = triState; // [R18]
  assign pciClkOe_n     = triState; // [R18]

  // ==========================================================================
  // status and synthesizer control; the core ramps between codes itself
  assign outputsRunning     = running;
  assign rate48_strap       = rate48_q;
  assign freq_select_straps = {fs1_q, fs0_q};
  assign freqCtrl.useRegs   = cfg_q.byte3[scs_pkg::B3TableSel]; // [R17]
  assign freqCtrl.sel       = cfg_q.byte3[scs_pkg::B3SelHi:scs_pkg::B3SelLo]; // [R17]
  assign freqCtrl.fsPins    = {fs1_q, fs0_q};
  assign freqCtrl.spreadOn  = (cfg_q.byte3[1:0] == scs_pkg::ModeSpreadOn);
  assign pllBypass          = testMode; // [R19]
  assign cfgByte6           = cfg_q.byte6;

endmodule

// *** scs_strap_cfg_props.sv ***
// assertions for the strap latch and serial configuration block
`timescale 1ns/1ps

// ============================================================================
// checker
module scs_strap_cfg_props #(
  parameter int unsigned SelectCount = 20
) (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 rst_n,
  // observed inputs
  input wire logic                 supplyOk,
  input wire logic                 crystal_in,
  input wire scs_pkg::scs_src_type clkSrc,
  // observed outputs
  input wire logic                 cfgSerialDataOut,
  input wire logic                 doubled_ref_out,
  input wire logic                 doubledRefOe_n,
  input wire logic                 usb_rate_out,
  input wire logic                 usbRateOe_n,
  input wire logic [1:0]           proc_clk_out,
  input wire logic                 procClkOe_n,
  input wire logic [6:0]           pciClkOut,
  input wire logic                 pciClkOe_n,
  input wire logic                 outputsRunning,
  input wire logic                 rate48_strap,
  input wire logic [1:0]           freq_select_straps,
  input wire logic                 pllBypass
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // waiting time with supply good; not cleared on a supply dip, benches keep it up
  logic [31:0] waitQ;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitQ <= 32'h0;
    end else if (supplyOk && !outputsRunning) begin
      waitQ <= waitQ + 32'h1;
    end
  end

  float_select_a: assert property (!outputsRunning |-> doubledRefOe_n && usbRateOe_n)
    else $error("dual pin driven before selection end");
  no_early_run_a: assert property (!supplyOk && !outputsRunning |=> !outputsRunning)
    else $error("outputs started without supply");
  run_bound_a: assert property (waitQ <= SelectCount + 6)
    else $error("selection period too long");
  select_length_a: assert property ($rose(outputsRunning) |-> waitQ >= SelectCount)
    else $error("selection period too short");
  latch_then_run_a: assert property ($changed({rate48_strap, freq_select_straps}) |-> ##[0:2] outputsRunning)
    else $error("straps latched without enabling outputs");
  strap_hold_a: assert property (outputsRunning |=> outputsRunning && $stable({rate48_strap, freq_select_straps}))
    else $error("strap latch changed while powered");
  write_only_a: assert property (cfgSerialDataOut == 1'b0)
    else $error("serial data driven high");
  ref_clock_a: assert property (!pllBypass && !doubledRefOe_n |-> doubled_ref_out == clkSrc.ref14)
    else $error("doubled pin not the reference clock");
  usb_rate_a: assert property (!pllBypass && usb_rate_out |-> (rate48_strap ? clkSrc.usb24 : clkSrc.usb48))
    else $error("usb pin rate does not match strap");
  tristate_all_a: assert property (outputsRunning && procClkOe_n |-> pciClkOe_n && doubledRefOe_n && usbRateOe_n)
    else $error("three-state not applied to all outputs");
  test_bypass_a: assert property (pllBypass && !doubledRefOe_n |-> doubled_ref_out == crystal_in)
    else $error("test mode output not from crystal");
  low_before_run_a: assert property (!outputsRunning |-> proc_clk_out == 2'h0 && pciClkOut == 7'h0)
    else $error("stopped clock outputs not held low");
endmodule

bind scs_strap_cfg scs_strap_cfg_props #(.SelectCount(SelectCount)) i_props (
  .clock(clock), .rst_n(rst_n), .supplyOk(supplyOk), .crystal_in(crystal_in), .clkSrc(clkSrc),
  .cfgSerialDataOut(cfgSerialDataOut), .doubled_ref_out(doubled_ref_out), .doubledRefOe_n(doubledRefOe_n),
  .usb_rate_out(usb_rate_out), .usbRateOe_n(usbRateOe_n), .proc_clk_out(proc_clk_out),
  .procClkOe_n(procClkOe_n), .pciClkOut(pciClkOut), .pciClkOe_n(pciClkOe_n),
  .outputsRunning(outputsRunning), .rate48_strap(rate48_strap),
  .freq_select_straps(freq_select_straps), .pllBypass(pllBypass)
);

// *** scs_host_model.sv ***
// chipset-side model writing configuration frames on the serial link
`timescale 1ns/1ps

// ============================================================================
// host model
module scs_host_model (
  // serial link, data is open drain with a pull-up
  output logic      sclk,
  output logic      sdaDrv_n,
  input  wire logic sda
);
  logic tick;

  // link base clock, 6 ns; serial clock idles high outside frames
  initial begin
    tick = 1'b0;
    sclk = 1'b1;
    sdaDrv_n = 1'b1;
  end
  always #3 tick = ~tick;

  // each phase is 60 ns so the design's synchroniser sees it
  task automatic half();
    repeat (10) @(posedge tick);
  endtask

  // ten bytes, first byte in the top bits; ack bit 9 is the address byte
  task automatic sendFrame(input logic [79:0] frame, output logic [9:0] ack);
    half();
    sdaDrv_n = 1'b0;
    half();
    sclk = 1'b0;
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < 8; k++) begin
        sdaDrv_n = frame[79 - 8 * i - k];
        half();
        sclk = 1'b1;
        half();
        sclk = 1'b0;
      end
      sdaDrv_n = 1'b1;
      half();
      ack[9 - i] = ~sda;
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    sdaDrv_n = 1'b0;
    half();
    sclk = 1'b1;
    half();
    sdaDrv_n = 1'b1;
    half();
  endtask
endmodule

// *** testbench.sv ***
// self-checking testbench for the strap latch and serial configuration block
`timescale 1ns/1ps

// ============================================================================
// testbench
module testbench;
  localparam int unsigned SelCnt = 20;
  localparam int unsigned Limit  = 40000;

  logic clock, rst_n, clockEn, supplyOk, refStrap, fs1Strap, fs0Strap;
  logic [5:0] srcCnt;
  logic sclk, sdaDrv_n, cfgSerialDataOut, cfgSerialDataOe_n, doubled_ref_out, doubledRefOe_n;
  logic usb_rate_out, usbRateOe_n, procClkOe_n, pciClkOe_n, outputsRunning, rate48_strap, pllBypass;
  logic [1:0] proc_clk_out, freq_select_straps;
  logic [6:0] pciClkOut;
  logic [7:0] cfgByte6;
  scs_pkg::scs_freq_type freqCtrl;
  int compares, miscompares, cycles;
  wire logic crystal_in = srcCnt[5];
  wire scs_pkg::scs_src_type clkSrc = scs_pkg::scs_src_type'(srcCnt[4:0]);
  // open-drain data with pull-up; dual pins show strap until driven
  wire logic sda = (cfgSerialDataOe_n | cfgSerialDataOut) & sdaDrv_n;
  wire logic refPin = doubledRefOe_n ? refStrap : doubled_ref_out;
  wire logic usbPin = usbRateOe_n ? fs1Strap : usb_rate_out;

  scs_strap_cfg #(.SelectCount(SelCnt)) i_dut (
    .clock(clock), .rst_n(rst_n), .clockEn(clockEn), .supplyOk(supplyOk), .crystal_in(crystal_in),
    .clkSrc(clkSrc), .freq_select_strap0(fs0Strap), .cfg_serial_clock(sclk), .cfgSerialDataIn(sda),
    .cfgSerialDataOut(cfgSerialDataOut), .cfgSerialDataOe_n(cfgSerialDataOe_n), .doubledRefIn(refPin),
    .doubled_ref_out(doubled_ref_out), .doubledRefOe_n(doubledRefOe_n), .usbRateIn(usbPin),
    .usb_rate_out(usb_rate_out), .usbRateOe_n(usbRateOe_n), .proc_clk_out(proc_clk_out),
    .procClkOe_n(procClkOe_n), .pciClkOut(pciClkOut), .pciClkOe_n(pciClkOe_n),
    .outputsRunning(outputsRunning), .rate48_strap(rate48_strap), .freq_select_straps(freq_select_straps),
    .freqCtrl(freqCtrl), .pllBypass(pllBypass), .cfgByte6(cfgByte6)
  );
  scs_host_model i_host (.sclk(sclk), .sdaDrv_n(sdaDrv_n), .sda(sda));

  always #5 clock = ~clock;
  always @(posedge clock) begin
    #1;
    srcCnt <= srcCnt + 6'h1;
  end

  // ==========================================================================
  // shared tasks
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == Limit) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // command, count and data bytes 0..2 carry junk that must be ignored
  function automatic logic [79:0] frm(input logic [7:0] adr, b3, b4, b5, b6);
    return {adr, 8'h3c, 8'h04, 8'hff, 8'h81, 8'h7e, b3, b4, b5, b6};
  endfunction

  task automatic wr(input logic [79:0] f, output logic [9:0] a);
    i_host.sendFrame(f, a);
    step(8);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_powerup();
    int n;
    n = 0;
    step(40);
    chk({outputsRunning, doubledRefOe_n, usbRateOe_n}, 3'b011);
    supplyOk = 1'b1;
    while (!outputsRunning && n < 200) begin
      step(1);
      n++;
    end
    chk((n >= SelCnt && n <= SelCnt + 6) ? 32'h1 : 32'h0, 32'h1);
    chk({rate48_strap, freq_select_straps}, 3'b101);
    chk({doubledRefOe_n, usbRateOe_n}, 2'b00);
    refStrap = 1'b0;
    fs1Strap = 1'b1;
    fs0Strap = 1'b0;
    step(10);
    chk({rate48_strap, freq_select_straps}, 3'b101);
    chk(freqCtrl, {1'b0, 4'h0, 2'b01, 1'b1});
    chk({pllBypass, cfgByte6}, 9'h000);
    $display("test powerup done");
  endtask

  task automatic t_badaddr();
    logic [9:0] a;
    for (int i = 0; i < 2; i++) begin
      wr(frm(i == 0 ? 8'hd3 : 8'hd0, 8'h98, 8'h45, 8'hef, 8'h5a), a);
      chk(a, 10'h000);
      chk({freqCtrl, cfgByte6}, {1'b0, 4'h0, 2'b01, 1'b1, 8'h00});
    end
    // a frozen block must neither acknowledge nor take a matching write
    clockEn = 1'b0;
    wr(frm(8'hd2, 8'h98, 8'h45, 8'hef, 8'h5a), a);
    clockEn = 1'b1;
    chk(a, 10'h000);
    chk({freqCtrl, cfgByte6}, {1'b0, 4'h0, 2'b01, 1'b1, 8'h00});
    $display("test bad address done");
  endtask

  task automatic t_write();
    logic [9:0] a;
    wr(frm(8'hd2, 8'h98, 8'h45, 8'hef, 8'ha5), a);
    chk(a, 10'h3ff);
    chk(freqCtrl, {1'b1, 4'h9, 2'b01, 1'b0});
    chk(cfgByte6, 8'ha5);
    $display("test write done");
  endtask

  task automatic t_disable();
    logic [9:0] a;
    logic [9:0] acc;
    acc = 10'h0;
    wr(frm(8'hd2, 8'h02, 8'h00, 8'h00, 8'h00), a);
    repeat (32) begin
      @(negedge clock);
      acc = acc | {proc_clk_out, pciClkOut, usb_rate_out};
    end
    chk(acc, 10'h000);
    chk({procClkOe_n, pciClkOe_n, usbRateOe_n}, 3'b000);
    $display("test disable done");
  endtask

  task automatic t_modes();
    logic [9:0] a;
    logic [2:0] acc;
    acc = 3'h0;
    wr(frm(8'hd2, 8'h01, 8'h45, 8'hef, 8'h00), a);
    chk(pllBypass, 1'b1);
    repeat (160) begin
      @(negedge clock);
      acc = acc | {doubled_ref_out ^ crystal_in, proc_clk_out ^ {2{crystal_in}}};
    end
    chk(acc, 3'h0);
    wr(frm(8'hd2, 8'h03, 8'h45, 8'hef, 8'h00), a);
    chk({procClkOe_n, pciClkOe_n, doubledRefOe_n, usbRateOe_n}, 4'hf);
    wr(frm(8'hd2, 8'h02, 8'h45, 8'hef, 8'h00), a);
    chk({pllBypass, procClkOe_n, usbRateOe_n, freqCtrl.spreadOn}, 4'h1);
    $display("test modes done");
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    clockEn = 1'b1;
    supplyOk = 1'b0;
    refStrap = 1'b1;
    fs1Strap = 1'b0;
    fs0Strap = 1'b1;
    srcCnt = 6'h00;
    compares = 0;
    miscompares = 0;
    cycles = 0;
    step(3);
    rst_n = 1'b1;
    t_powerup();
    t_badaddr();
    t_write();
    t_disable();
    t_modes();
    complete_run();
  end
endmodule
